//--- src/spsc_pkg.sv
/*
  spsc_pkg: constants shared by the supply protection and soft-start
  control block. assumes a single 40 MHz clock domain.
*/
package spsc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CT_OFFSET_TRIM_ADDR = 8'h15;
  localparam logic [7:0] SS_RATE_ADDR = 8'h20;
  localparam logic [7:0] OC_TIMER_ADDR = 8'h21;
  localparam logic [7:0] CS_CFG_ADDR = 8'h22;
  localparam logic [7:0] TRIM_LOV_ADDR = 8'h23;
  localparam logic [7:0] TRIM_OV_ADDR = 8'h24;
  localparam logic [7:0] TRIM_UV_ADDR = 8'h25;
  localparam logic [7:0] CMD_ADDR = 8'h26;
  localparam logic [7:0] STATUS_ADDR = 8'h27;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CT_OFFSET_TRIM_RST = 8'h0f;
  localparam logic [7:0] SS_RATE_RST = 8'h04;
  localparam logic [7:0] OC_TIMER_RST = 8'h08;
  localparam logic [7:0] CS_CFG_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h80;
  // ----------------------------------------------------------------
  // field positions and limits of the current-sense config, offset trim and command registers
  // ----------------------------------------------------------------
  localparam int CFG_CHOP_BIT = 0;
  localparam int CFG_RANGE_LSB = 1;
  localparam int CFG_BUF21_BIT = 3;
  localparam int CFG_CT_BIT = 4;
  localparam int CFG_CTSENS_BIT = 5;
  localparam int CFG_AUTORST_BIT = 6;
  localparam int CT_TRIM_W = 5;
  localparam int CMD_CLEAR_BIT = 0;
  localparam logic [1:0] RANGE_MAX = 2'h2;
  localparam logic [2:0] OFS_RANGE_MAX = 3'h5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SS_STEPS = 127;
  localparam int OC_TICK_US = 100;
  localparam int OC_TICK_CYC = OC_TICK_US * (CLK_HZ / 1_000_000);
  localparam int RESTART_MS = 1000;
  localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
  typedef enum logic [3:0] {
    SPSC_OFF = 4'b0001,
    SPSC_RAMP = 4'b0010,
    SPSC_RUN = 4'b0100,
    SPSC_FAULT = 4'b1000
  } spsc_state_type;
endpackage

//--- src/spsc_ss_ramp.sv
/*
  spsc_ss_ramp: soft-start reference counter feeding the reference DAC.
  assumes run is a same-clock level from the supervisor.
*/
`timescale 1ns/1ps
module spsc_ss_ramp import spsc_pkg::*; #(
  parameter int STEPS = SS_STEPS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [7:0] rate,
  // dac code and done
  output logic [6:0] code,
  output logic done
);
  if (STEPS < 1 || STEPS > 127) begin : g_steps_chk
    $error("ramp steps out of range");
  end
  logic [15:0] div_r;
  logic [6:0] code_r;
  wire div_top = (div_r >= {rate, 8'h00});
  wire at_top = (code_r == 7'(STEPS));
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // RQ22: steps to final
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      div_r <= 16'h0000;
      code_r <= 7'h00;
    end else if (div_top) begin
      div_r <= 16'h0000;
      // RQ8: counter drives dac
      if (!at_top) code_r <= code_r + 7'h01;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign code = code_r;
  assign done = at_top;
  ramp_top_a: assert property (@(posedge sys_clk) disable iff (reset)
    code_r == 7'(STEPS) && run |=> code_r == 7'(STEPS)) // RQ22
    else $error("ramp left its top");
endmodule

//--- src/spsc_ctl.sv
/*
  spsc_ctl: supply-good qualification, fault latching, overcurrent timer,
  soft-start sequencing and current-sense configuration of a secondary
  controller. assumes analog comparator levels arrive asynchronously on
  pins and that the serial port decodes writes into addr/data strobes.
*/
//
// Behaviour
// RQ1: supply good needs all four conditions
// RQ2: ground fault drops supply good
// RQ3: reference buffer off until upper lockout
// RQ4: load overvoltage turns switch off, unlatched
// RQ5: local overvoltage only after load overvoltage
// RQ6: overvoltage and undervoltage thresholds trimmable
// RQ7: overcurrent fault disables false undervoltage clamp
// RQ8: reference ramped by counter and dac
// RQ9: chopped or linear current amplifier
// RQ10: six gain ranges from range and buffer
// RQ11: transformer sensing disables resistive path
// RQ12: transformer mode forces buffer gain one
// RQ13: transformer amplifier two sensitivities
// RQ14: five-bit transformer offset trim
// RQ15: six offset compensation ranges
// RQ16: overcurrent timer expiry declares fault
// RQ17: early clear resets timer silently
// RQ18: timer period written over serial port
// RQ19: timer running blanks undervoltage
// RQ20: overcurrent latches or restarts per mode
// RQ21: overvoltage latches until request, supply, command
// RQ22: ramp in about 127 steps
// RQ23: undervoltage blanked at power-up, low line
// RQ24: timers run on internal clock
`timescale 1ns/1ps
module spsc_ctl import spsc_pkg::*; #(
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // analog monitor pins
  input wire logic gnd_below_sense,
  input wire logic refs_ok,
  input wire logic above_lockout_upper,
  input wire logic supply_ov,
  input wire logic load_ov_cmp,
  input wire logic local_ov_cmp,
  input wire logic local_uv_cmp,
  input wire logic oc_cmp,
  input wire logic supply_on_request,
  input wire logic line_sense_status,
  // register write/read port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // converter controls
  output logic supply_good,
  output logic ref_buf_en,
  output logic output_isolation_switch,
  output logic converter_en,
  output logic false_uv_clamp_en,
  output logic overcurrent_fault_flag,
  output logic [6:0] ref_dac_code,
  output logic [7:0] load_ov_trim,
  output logic [7:0] local_ov_trim,
  output logic [7:0] local_uv_trim,
  output logic chop_en,
  output logic [1:0] amp_range,
  output logic buf_gain_21,
  output logic resistive_en,
  output logic ct_sens_hi,
  output logic [4:0] ct_offset_code,
  output logic [2:0] ofs_range
);
  // the restart counter is 28 bits wide
  if (RESTART_CYCLES < 1 || RESTART_CYCLES >= (1 << 28)) begin : g_rst_chk
    $error("restart cycles out of range");
  end
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 10;
  logic [NS-1:0] s1_r, s2_r;
  always_ff @(posedge sys_clk) begin
    s1_r <= {line_sense_status, supply_on_request, oc_cmp, local_uv_cmp,
      local_ov_cmp, load_ov_cmp, supply_ov, above_lockout_upper, refs_ok,
      gnd_below_sense};
    s2_r <= s1_r;
  end
  wire gnd_ok = s2_r[0];
  wire ref_ok = s2_r[1];
  wire lock_hi = s2_r[2];
  wire vdd_ov = s2_r[3];
  wire lov = s2_r[4];
  wire ov = s2_r[5];
  wire uv = s2_r[6];
  wire oc = s2_r[7];
  wire son = s2_r[8];
  wire line_ok = s2_r[9];
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ct_offset_current_trim_r, ss_rate_r, oc_timer_r, cs_cfg_r;
  logic [7:0] trim_lov_r, trim_ov_r, trim_uv_r;
  wire wr_ct = reg_wr && reg_addr == CT_OFFSET_TRIM_ADDR;
  wire clr_cmd = reg_wr && reg_addr == CMD_ADDR && reg_wdata[CMD_CLEAR_BIT];
  // RQ6: threshold trims
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ct_offset_current_trim_r <= CT_OFFSET_TRIM_RST;
      ss_rate_r <= SS_RATE_RST;
      oc_timer_r <= OC_TIMER_RST;
      cs_cfg_r <= CS_CFG_RST;
      trim_lov_r <= TRIM_RST;
      trim_ov_r <= TRIM_RST;
      trim_uv_r <= TRIM_RST;
    end else if (reg_wr) begin
      if (wr_ct) ct_offset_current_trim_r <= reg_wdata;
      if (reg_addr == SS_RATE_ADDR) ss_rate_r <= reg_wdata;
      // RQ18: timer period
      if (reg_addr == OC_TIMER_ADDR) oc_timer_r <= reg_wdata;
      if (reg_addr == CS_CFG_ADDR) cs_cfg_r <= reg_wdata;
      if (reg_addr == TRIM_LOV_ADDR) trim_lov_r <= reg_wdata;
      if (reg_addr == TRIM_OV_ADDR) trim_ov_r <= reg_wdata;
      if (reg_addr == TRIM_UV_ADDR) trim_uv_r <= reg_wdata;
    end
  end
  // ----------------------------------------------------------------
  // supply good and reference
  // ----------------------------------------------------------------
  // RQ1: all four conditions
  // RQ2: ground fault drops
  wire good_nxt = gnd_ok && ref_ok && lock_hi && !vdd_ov;
  // ----------------------------------------------------------------
  // overcurrent timer
  // ----------------------------------------------------------------
  logic [23:0] oc_cnt_r;
  logic oc_fault_r, ov_fault_r, lov_seen_r;
  wire [23:0] oc_limit = 24'(oc_timer_r) * 24'(OC_TICK_CYC);
  wire oc_expire = oc && oc_cnt_r >= oc_limit && oc_limit != 24'h0;
  wire oc_running = oc && !oc_fault_r;
  // RQ16: timer on trip
  // RQ17: clear resets timer
  // RQ24: internal clock count
  always_ff @(posedge sys_clk) begin
    if (reset || !oc || oc_fault_r) oc_cnt_r <= 24'h000000;
    else oc_cnt_r <= oc_cnt_r + 24'h000001;
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  spsc_state_type st_r, st_nxt;
  logic [27:0] rst_cnt_r;
  logic son_d_r;
  wire ramp_done;
  wire autorst = cs_cfg_r[CFG_AUTORST_BIT];
  // RQ23: power-up and low line
  // RQ19: timer blanks uv
  wire uv_blank = st_r != SPSC_RUN || !line_ok || oc_running;
  wire uv_fault = uv && !uv_blank;
  wire restart_due = rst_cnt_r >= 28'(RESTART_CYCLES);
  wire son_rise = son && !son_d_r;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SPSC_OFF: if (son && good_nxt && !ov_fault_r && !oc_fault_r)
        st_nxt = SPSC_RAMP;
      SPSC_RAMP: if (ramp_done) st_nxt = SPSC_RUN;
      SPSC_RUN: ;
      SPSC_FAULT: ;
      default: st_nxt = SPSC_OFF;
    endcase
    if (st_r != SPSC_OFF && st_r != SPSC_FAULT &&
        (!son || !good_nxt || ov_fault_r || oc_expire || uv_fault))
      st_nxt = SPSC_FAULT;
    // RQ20: autorestart or latch
    if (st_r == SPSC_FAULT && !ov_fault_r &&
        (!oc_fault_r || (autorst && restart_due)))
      st_nxt = SPSC_OFF;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= SPSC_OFF;
      rst_cnt_r <= 28'h0000000;
      son_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      son_d_r <= son;
      rst_cnt_r <= (st_r == SPSC_FAULT) ? rst_cnt_r + 28'h0000001
        : 28'h0000000;
    end
  end
  // ----------------------------------------------------------------
  // fault latches; a new event wins over a clear
  // ----------------------------------------------------------------
  wire ov_clear = clr_cmd || son_rise || !lock_hi;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ov_fault_r <= 1'b0;
      oc_fault_r <= 1'b0;
      lov_seen_r <= 1'b0;
    end else begin
      lov_seen_r <= lov ? 1'b1 : (ov_clear ? 1'b0 : lov_seen_r);
      // RQ5: ov after load ov
      // RQ21: ov fault latches until cleared
      if ((ov && (lov_seen_r || lov)) || !gnd_ok) ov_fault_r <= 1'b1;
      else if (ov_clear) ov_fault_r <= 1'b0;
      if (oc_expire) oc_fault_r <= 1'b1;
      else if (clr_cmd || son_rise ||
          (st_r == SPSC_FAULT && autorst && restart_due))
        oc_fault_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // soft start
  // ----------------------------------------------------------------
  wire [6:0] dac_w;
  spsc_ss_ramp #(.STEPS(SS_STEPS)) u_ramp (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(st_r == SPSC_RAMP || st_r == SPSC_RUN),
    .rate(ss_rate_r),
    .code(dac_w),
    .done(ramp_done)
  );
  // ----------------------------------------------------------------
  // current-sense config decode
  // ----------------------------------------------------------------
  wire is_ct = cs_cfg_r[CFG_CT_BIT];
  wire [1:0] rng = cs_cfg_r[CFG_RANGE_LSB +: 2];
  // RQ10: clamp to three ranges
  wire [1:0] rng_ok = (rng > RANGE_MAX) ? RANGE_MAX : rng;
  // RQ15: six offset ranges
  wire [2:0] ofs_w = cs_cfg_r[7] ? OFS_RANGE_MAX
    : {ct_offset_current_trim_r[7:5] > OFS_RANGE_MAX ? OFS_RANGE_MAX
      : ct_offset_current_trim_r[7:5]};
  wire [7:0] status_w = {3'h0, ramp_done, oc_running, oc_fault_r,
    ov_fault_r, good_nxt};
  wire [7:0] rd_w =
    reg_addr == CT_OFFSET_TRIM_ADDR ? ct_offset_current_trim_r :
    reg_addr == SS_RATE_ADDR ? ss_rate_r :
    reg_addr == OC_TIMER_ADDR ? oc_timer_r :
    reg_addr == CS_CFG_ADDR ? cs_cfg_r :
    reg_addr == TRIM_LOV_ADDR ? trim_lov_r :
    reg_addr == TRIM_OV_ADDR ? trim_ov_r :
    reg_addr == TRIM_UV_ADDR ? trim_uv_r :
    reg_addr == STATUS_ADDR ? status_w : 8'h00;
  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      supply_good <= 1'b0;
      ref_buf_en <= 1'b0;
      output_isolation_switch <= 1'b0;
      converter_en <= 1'b0;
      false_uv_clamp_en <= 1'b0;
      overcurrent_fault_flag <= 1'b0;
      ref_dac_code <= 7'h00;
      load_ov_trim <= TRIM_RST;
      local_ov_trim <= TRIM_RST;
      local_uv_trim <= TRIM_RST;
      chop_en <= 1'b0;
      amp_range <= 2'h0;
      buf_gain_21 <= 1'b0;
      resistive_en <= 1'b1;
      ct_sens_hi <= 1'b0;
      ct_offset_code <= 5'h00;
      ofs_range <= 3'h0;
      reg_rdata <= 8'h00;
    end else begin
      supply_good <= good_nxt;
      // RQ3: ref after lockout
      ref_buf_en <= lock_hi;
      // RQ4: switch off on load ov
      output_isolation_switch <= (st_r == SPSC_RUN) && !lov;
      converter_en <= st_nxt == SPSC_RAMP || st_nxt == SPSC_RUN;
      // RQ7: clamp off on oc fault
      false_uv_clamp_en <= !oc_fault_r && !oc_expire;
      overcurrent_fault_flag <= oc_fault_r || oc_expire;
      ref_dac_code <= dac_w;
      load_ov_trim <= trim_lov_r;
      local_ov_trim <= trim_ov_r;
      local_uv_trim <= trim_uv_r;
      // RQ9: chop select
      chop_en <= cs_cfg_r[CFG_CHOP_BIT];
      amp_range <= rng_ok;
      // RQ12: ct forces unity
      buf_gain_21 <= cs_cfg_r[CFG_BUF21_BIT] && !is_ct;
      // RQ11: ct disables resistive
      resistive_en <= !is_ct;
      // RQ13: ct sensitivity
      ct_sens_hi <= cs_cfg_r[CFG_CTSENS_BIT];
      // RQ14: five-bit offset code
      ct_offset_code <= ct_offset_current_trim_r[CT_TRIM_W-1:0];
      ofs_range <= ofs_w;
      reg_rdata <= rd_w;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  good_cond_a: assert property (@(posedge sys_clk) disable iff (reset)
    !gnd_ok |=> !supply_good) // RQ2
    else $error("supply good with ground fault");
  good_all_a: assert property (@(posedge sys_clk) disable iff (reset)
    supply_good |-> $past(ref_ok && lock_hi && !vdd_ov)) // RQ1
    else $error("supply good without conditions");
  ref_buf_a: assert property (@(posedge sys_clk) disable iff (reset)
    ref_buf_en |-> $past(lock_hi)) // RQ3
    else $error("reference enabled below lockout");
  switch_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    lov |=> !output_isolation_switch) // RQ4
    else $error("switch on during load ov");
  clamp_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    overcurrent_fault_flag |-> !false_uv_clamp_en) // RQ7
    else $error("clamp on during oc fault");
  oc_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    !oc |=> oc_cnt_r == 24'h0) // RQ17
    else $error("timer not reset");
  ov_latch_a: assert property (@(posedge sys_clk) disable iff (reset)
    ov_fault_r && !ov_clear |=> ov_fault_r) // RQ21
    else $error("ov fault lost");
  ct_gain_a: assert property (@(posedge sys_clk) disable iff (reset)
    is_ct |=> !buf_gain_21 && !resistive_en) // RQ12
    else $error("ct mode gain not forced");
  uv_blank_a: assert property (@(posedge sys_clk) disable iff (reset)
    oc_running && st_r == SPSC_RUN && son && good_nxt && !ov_fault_r &&
    !oc_expire |=> st_r != SPSC_FAULT) // RQ19
    else $error("uv raised during ride-through");
  run_c: cover property (@(posedge sys_clk) st_r == SPSC_RUN);
  ocf_c: cover property (@(posedge sys_clk) oc_expire);
  ovf_c: cover property (@(posedge sys_clk) $rose(ov_fault_r));
endmodule

//--- dv/spsc_conv_model.sv
/*
  spsc_conv_model: behavioural far side of the supply control block, the
  analog converter stage and its comparators. assumes the bench sets a
  stress vector on falling clock edges; comparator levels follow it.
*/
`timescale 1ns/1ps
module spsc_conv_model (
  // converter state from the block
  input wire logic converter_en,
  // stress vector: 0 gnd lift, 1 ref bad, 2 vdd low, 3 vdd high,
  // 4 load high, 5 local high, 6 local low, 7 overload, 8 line low
  input wire logic [8:0] stress,
  // comparator levels to the block
  output logic gnd_below_sense,
  output logic refs_ok,
  output logic above_lockout_upper,
  output logic supply_ov,
  output logic load_ov_cmp,
  output logic local_ov_cmp,
  output logic local_uv_cmp,
  output logic oc_cmp,
  output logic line_sense_status
);
  // ----------------------------------------------------------------
  // comparator levels
  // ----------------------------------------------------------------
  assign gnd_below_sense = !stress[0];
  assign refs_ok = !stress[1];
  assign above_lockout_upper = !stress[2];
  assign supply_ov = stress[3];
  assign load_ov_cmp = stress[4];
  assign local_ov_cmp = stress[5];
  assign local_uv_cmp = stress[6];
  // no current flows once the converter is stopped
  assign oc_cmp = stress[7] & converter_en;
  assign line_sense_status = !stress[8];
endmodule

//--- dv/tb.sv
/*
  tb: self-checking bench for spsc_ctl with the converter model.
  assumes the registered write/read port and 2-flop pin synchronisers.
*/
`timescale 1ns/1ps
module tb;
  import spsc_pkg::*;
  logic sys_clk, reset, supply_on_request, reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, load_ov_trim, local_ov_trim;
  logic [7:0] local_uv_trim;
  logic gnd_below_sense, refs_ok, above_lockout_upper, supply_ov;
  logic load_ov_cmp, local_ov_cmp, local_uv_cmp, oc_cmp, line_sense_status;
  logic supply_good, ref_buf_en, output_isolation_switch, converter_en;
  logic false_uv_clamp_en, overcurrent_fault_flag, chop_en, buf_gain_21;
  logic resistive_en, ct_sens_hi;
  logic [6:0] ref_dac_code, prev_code;
  logic [1:0] amp_range;
  logic [4:0] ct_offset_code;
  logic [2:0] ofs_range;
  logic [8:0] stress;
  int mismatches, checks, n, steps;
  logic [7:0] rst_addr [8] = '{8'h15, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
                               8'h25, 8'h30};
  logic [7:0] rst_val [8] = '{8'h0f, 8'h04, 8'h08, 8'h00, 8'h80, 8'h80,
                              8'h80, 8'h00};

  spsc_ctl #(.RESTART_CYCLES(100)) dut (.sys_clk(sys_clk), .reset(reset),
    .gnd_below_sense(gnd_below_sense), .refs_ok(refs_ok),
    .above_lockout_upper(above_lockout_upper), .supply_ov(supply_ov),
    .load_ov_cmp(load_ov_cmp), .local_ov_cmp(local_ov_cmp),
    .local_uv_cmp(local_uv_cmp), .oc_cmp(oc_cmp),
    .supply_on_request(supply_on_request),
    .line_sense_status(line_sense_status), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_good(supply_good), .ref_buf_en(ref_buf_en),
    .output_isolation_switch(output_isolation_switch),
    .converter_en(converter_en), .false_uv_clamp_en(false_uv_clamp_en),
    .overcurrent_fault_flag(overcurrent_fault_flag),
    .ref_dac_code(ref_dac_code), .load_ov_trim(load_ov_trim),
    .local_ov_trim(local_ov_trim), .local_uv_trim(local_uv_trim),
    .chop_en(chop_en), .amp_range(amp_range), .buf_gain_21(buf_gain_21),
    .resistive_en(resistive_en), .ct_sens_hi(ct_sens_hi),
    .ct_offset_code(ct_offset_code), .ofs_range(ofs_range));

  spsc_conv_model model (.converter_en(converter_en), .stress(stress),
    .gnd_below_sense(gnd_below_sense), .refs_ok(refs_ok),
    .above_lockout_upper(above_lockout_upper), .supply_ov(supply_ov),
    .load_ov_cmp(load_ov_cmp), .local_ov_cmp(local_ov_cmp),
    .local_uv_cmp(local_uv_cmp), .oc_cmp(oc_cmp),
    .line_sense_status(line_sense_status));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // strobe held one cycle, then one idle cycle so registered outputs settle before the caller checks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    cyc(1);
    chk(reg_rdata, exp);
  endtask
  // counts dac steps; a jump of more than one code is an error
  task automatic ramp_wait();
    n = 0;
    steps = 0;
    prev_code = ref_dac_code;
    while (ref_dac_code !== 7'h7f && n < 2000) begin
      cyc(1);
      n++;
      if (ref_dac_code !== prev_code) begin
        steps++;
        if (ref_dac_code !== prev_code + 7'h01)
          chk(8'(ref_dac_code), 8'(prev_code + 7'h01));
      end
      prev_code = ref_dac_code;
    end
    cyc(8);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // run needs about 12k cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    supply_on_request = 1'b0;
    stress = 9'h004;
    mismatches = 0;
    checks = 0;
    cyc(3);
    reset = 1'b0;
    cyc(4);
    chk(8'(ref_buf_en), 8'h00);
    chk(8'(supply_good), 8'h00);
    chk(8'(resistive_en), 8'h01);
    chk(8'(false_uv_clamp_en), 8'h01);
    for (int i = 0; i < 8; i++) rd(rst_addr[i], rst_val[i]);
    $display("test reset done");
    stress = 9'h000;
    cyc(4);
    chk(8'(ref_buf_en), 8'h01);
    chk(8'(supply_good), 8'h01);
    for (int i = 0; i < 4; i++) begin
      stress = 9'(1 << i);
      cyc(4);
      chk(8'(supply_good), 8'h00);
      stress = 9'h000;
      cyc(4);
      wr(CMD_ADDR, 8'h01);
      cyc(4);
      chk(8'(supply_good), 8'h01);
    end
    $display("test supply good done");
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 2; b++) begin
        wr(CS_CFG_ADDR, 8'((b << 3) | (r << 1) | (r & 1)));
        chk(8'(amp_range), 8'(r));
        chk(8'(buf_gain_21), 8'(b));
        chk(8'(chop_en), 8'(r & 1));
      end
    end
    wr(CS_CFG_ADDR, 8'h86);
    chk(8'(amp_range), 8'h02);
    chk(8'(ofs_range), 8'h05);
    wr(CS_CFG_ADDR, 8'h38);
    chk(8'(resistive_en), 8'h00);
    chk(8'(buf_gain_21), 8'h00);
    chk(8'(ct_sens_hi), 8'h01);
    wr(CS_CFG_ADDR, 8'h00);
    chk(8'(resistive_en), 8'h01);
    for (int k = 0; k < 6; k++) begin
      wr(CT_OFFSET_TRIM_ADDR, 8'((k << 5) | (k * 5 + 1)));
      chk(8'(ofs_range), 8'(k));
      chk(8'(ct_offset_code), 8'(k * 5 + 1));
      rd(CT_OFFSET_TRIM_ADDR, 8'((k << 5) | (k * 5 + 1)));
    end
    wr(TRIM_LOV_ADDR, 8'h33);
    wr(TRIM_OV_ADDR, 8'h44);
    wr(TRIM_UV_ADDR, 8'h55);
    chk(load_ov_trim, 8'h33);
    chk(local_ov_trim, 8'h44);
    chk(local_uv_trim, 8'h55);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    $display("test config done");
    wr(SS_RATE_ADDR, 8'h00);
    wr(OC_TIMER_ADDR, 8'h01);
    supply_on_request = 1'b1;
    ramp_wait();
    chk(8'(steps), 8'd127);
    rd(STATUS_ADDR, 8'h11);
    chk(8'(ref_dac_code), 8'h7f);
    chk(8'(converter_en), 8'h01);
    chk(8'(output_isolation_switch), 8'h01);
    // local ov before any load ov must not shut down
    stress = 9'h020;
    cyc(8);
    chk(8'(converter_en), 8'h01);
    stress = 9'h010;
    cyc(4);
    chk(8'(output_isolation_switch), 8'h00);
    stress = 9'h000;
    cyc(4);
    chk(8'(output_isolation_switch), 8'h01);
    stress = 9'h140;
    cyc(8);
    chk(8'(converter_en), 8'h01);
    stress = 9'h040;
    cyc(8);
    chk(8'(ref_dac_code == 7'h7f), 8'h00);
    stress = 9'h000;
    ramp_wait();
    chk(8'(converter_en), 8'h01);
    $display("test ramp done");
    stress = 9'h0c0;
    cyc(2000);
    stress = 9'h000;
    cyc(8);
    chk(8'(overcurrent_fault_flag), 8'h00);
    chk(8'(converter_en), 8'h01);
    stress = 9'h080;
    cyc(3900);
    chk(8'(overcurrent_fault_flag), 8'h00);
    cyc(200);
    chk(8'(overcurrent_fault_flag), 8'h01);
    chk(8'(false_uv_clamp_en), 8'h00);
    stress = 9'h000;
    cyc(300);
    chk(8'(converter_en), 8'h00);
    rd(STATUS_ADDR, 8'h05);
    wr(CMD_ADDR, 8'h01);
    ramp_wait();
    chk(8'(converter_en), 8'h01);
    $display("test overcurrent done");
    stress = 9'h030;
    cyc(8);
    chk(8'(converter_en), 8'h00);
    stress = 9'h000;
    cyc(300);
    chk(8'(converter_en), 8'h00);
    supply_on_request = 1'b0;
    cyc(8);
    supply_on_request = 1'b1;
    ramp_wait();
    chk(8'(converter_en), 8'h01);
    $display("test overvoltage done");
    wr(CS_CFG_ADDR, 8'h40);
    stress = 9'h080;
    cyc(4100);
    chk(8'(overcurrent_fault_flag), 8'h01);
    stress = 9'h000;
    n = 0;
    while (converter_en !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(8'(converter_en), 8'h01);
    $display("test restart done");
    finish_test();
  end
endmodule
